// ===== verilog/iso_evt_core.sv
`timescale 1ns/1ns
`default_nettype none
module iso_evt_core
   import iso_evt_pkg::*;
(
   input wire logic i_clk_sys, // 10 MHz block clock
   input wire logic i_nrst, // Async reset, active low
   // Avalon-MM slave
   input wire logic [7:0] i_avs_address, // Byte address
   input wire logic i_avs_read, // Read request
   input wire logic i_avs_write, // Write request
   input wire logic [31:0] i_avs_writedata, // Write data
   input wire logic [3:0] i_avs_byteenable, // Byte lanes
   output logic [31:0] o_avs_readdata, // Read data
   output logic o_avs_waitrequest, // Stall
   // Interrupt mask register contents
   input wire logic [31:0] i_intr_mask, // Gates event reads
   // Channel filter
   input wire logic i_iso_rx_valid, // Packet header seen
   input wire logic [5:0] i_iso_rx_channel, // Its channel number
   output logic o_iso_rx_accept, // Packet taken
   output logic [31:0] o_rx_channel_mask, // Channel enables
   // Event sources
   input wire logic i_rx_fifo_pending, // Receive data waits for host
   input wire logic i_phys_resp_busy, // Physical responder busy
   input wire logic i_ack_tardy_sent, // Tardy ack sent
   input wire logic i_phy_reg_byte_received, // PHY register byte in
   input wire logic [CTX_NUM-1:0] i_context_dead, // Context stopped
   input wire logic i_cycle_start_tx, // Cycle start send begins
   input wire logic i_subaction_gap_end, // Subaction gap ended
   input wire logic i_rx_cycle_start, // Cycle start received
   input wire logic [6:0] i_rx_cycle_seconds_count, // Its seconds
   input wire logic [12:0] i_rx_cycle_count_value, // Its count
   input wire logic [31:0] i_local_cycle_time, // Local cycle timer
   input wire logic [CTX_NUM-1:0] i_iso_rx_ctx_event, // Rx context events
   input wire logic [CTX_NUM-1:0] i_iso_rx_ctx_mask, // Rx context masks
   input wire logic [CTX_NUM-1:0] i_iso_tx_ctx_event, // Tx context events
   input wire logic [CTX_NUM-1:0] i_iso_tx_ctx_mask, // Tx context masks
   // Effects
   output logic o_cycle_master_role, // Cycle master role
   output logic o_late_ack_event_enable, // Late-ack event enable
   output logic [CTX_NUM-1:0] o_ctx_irq_block // Block context irqs
);

   // ----------------------------------------
   // Reset release
   // ----------------------------------------
   logic [1:0] rst_sync_reg;
   logic rst_n;

   always_ff @(posedge i_clk_sys or negedge i_nrst) begin
      if (!i_nrst) begin
         rst_sync_reg <= 2'b00;
      end else begin
         rst_sync_reg <= {rst_sync_reg[0], 1'b1};
      end
   end

   assign rst_n = rst_sync_reg[1];

   // ----------------------------------------
   // Helpers
   // ----------------------------------------
   function automatic logic [31:0] lane_mask(input logic [3:0] be);
      logic [31:0] m;
      m = '0;
      for (int i = 0; i < 4; i++) begin
         m[i*8 +: 8] = {8{be[i]}};
      end
      return m;
   endfunction

   // Source edges; all sources share this clock, so no synchroniser
   logic [EDGE_NUM-1:0] lvl;
   logic [EDGE_NUM-1:0] rise;
   logic [CTX_NUM-1:0] dead_rise;
   logic late_rise;

   assign lvl = {i_context_dead, i_phy_reg_byte_received, i_ack_tardy_sent,
                 i_phys_resp_busy, i_rx_fifo_pending};

   rise_detect #(
      .W(EDGE_NUM)
   ) u_rise (
      .i_clk_sys(i_clk_sys),
      .i_rst_n(rst_n),
      .i_level(lvl),
      .o_rise(rise)
   );

   assign late_rise = |rise[2:0];
   assign dead_rise = rise[EDGE_NUM-1:4];

   // ----------------------------------------
   // State
   // ----------------------------------------
   evt_state_t st;
   evt_state_t st_next;

   logic [31:0] evt_view;
   logic [31:0] wmask;
   logic [31:0] wbits;
   logic [31:0] hw_set;
   logic [31:0] evt_clr;
   logic [31:0] evt_set;
   logic mismatch;
   logic commit;

   // Read view of the event register
   always_comb begin
      evt_view = st.event_bits & EVT_LATCH_MASK; // R07
      evt_view[BIT_ISO_RX] = |(i_iso_rx_ctx_event & i_iso_rx_ctx_mask); // R16
      evt_view[BIT_ISO_TX] = |(i_iso_tx_ctx_event & i_iso_tx_ctx_mask); // R16
      evt_view = evt_view & i_intr_mask; // R06
   end

   assign mismatch = (i_rx_cycle_seconds_count != i_local_cycle_time[31:25]) ||
                     (i_rx_cycle_count_value != i_local_cycle_time[24:12]);

   assign wmask = lane_mask(i_avs_byteenable);
   assign wbits = i_avs_writedata & wmask;
   // Write lands at the edge where waitrequest is seen low
   assign commit = i_avs_write & ~st.wait_req;

   always_comb begin
      st_next = st;
      hw_set = '0;
      evt_set = '0;
      evt_clr = '0;

      // ----------------------------------------
      // Channel filter
      // ----------------------------------------
      st_next.accept = i_iso_rx_valid & ~i_iso_rx_channel[5] &
                       st.chan_mask[i_iso_rx_channel[4:0]]; // R01

      // ----------------------------------------
      // Cycle overrun timer
      // ----------------------------------------
      if (!st.master) begin
         st_next.ovr_run = 1'b0;
      end else if (i_cycle_start_tx) begin
         st_next.ovr_run = 1'b1;
         st_next.ovr_cnt = '0;
      end else if (st.ovr_run) begin
         if (i_subaction_gap_end) begin
            st_next.ovr_run = 1'b0;
         end else if (st.ovr_cnt == OVR_LIMIT) begin
            // One cycle past the limit: strictly over 125 us
            hw_set[BIT_OVERRUN] = 1'b1; // R11
            st_next.ovr_run = 1'b0;
         end else begin
            st_next.ovr_cnt = st.ovr_cnt + OVR_W'(1);
         end
      end

      // ----------------------------------------
      // Hardware event sources
      // ----------------------------------------
      hw_set[BIT_LATE_ACK] = st.late_ack_en & late_rise; // R09
      hw_set[BIT_PHY_REG] = rise[3]; // R10
      hw_set[BIT_FATAL] = |dead_rise; // R13
      hw_set[BIT_MISMATCH] = i_rx_cycle_start & mismatch; // R15
      // Bit 29 gets no hardware source
      hw_set[BIT_SOFTWARE] = 1'b0; // R08

      // ----------------------------------------
      // Register writes
      // ----------------------------------------
      if (commit) begin
         case (i_avs_address)
            ADDR_MASK_SET: begin
               st_next.chan_mask = st.chan_mask | wbits; // R02 R17
            end
            ADDR_MASK_CLR: begin
               st_next.chan_mask = st.chan_mask & ~wbits; // R02 R17
            end
            ADDR_EVT_SET: begin
               evt_set = wbits & EVT_LATCH_MASK; // R04 R08 R17
            end
            ADDR_EVT_CLR: begin
               evt_clr = wbits & EVT_LATCH_MASK; // R05 R17
            end
            ADDR_CTRL: begin
               if (i_avs_byteenable[0]) begin
                  st_next.late_ack_en = i_avs_writedata[CTRL_LATE_ACK_EN];
                  st_next.master = i_avs_writedata[CTRL_MASTER];
               end
            end
            default: begin
            end
         endcase
      end

      // Overrun beats a software write of the role bit
      if (hw_set[BIT_OVERRUN]) begin
         st_next.master = 1'b0; // R12
      end

      // Hardware and software sets both win over a clear in the same cycle
      st_next.event_bits = ((st.event_bits & ~evt_clr) | evt_set | hw_set) &
                           EVT_LATCH_MASK; // R04 R05

      // ----------------------------------------
      // Fatal error context tracking
      // ----------------------------------------
      if (!st_next.event_bits[BIT_FATAL]) begin
         st_next.fatal_src = '0;
      end else begin
         st_next.fatal_src = st.fatal_src | dead_rise;
      end
      st_next.irq_block = st_next.fatal_src; // R14

      // ----------------------------------------
      // Bus handshake: one wait cycle, then one ready cycle
      // ----------------------------------------
      if ((i_avs_read | i_avs_write) & st.wait_req) begin
         st_next.wait_req = 1'b0;
         st_next.rdata = '0;
         if (i_avs_read) begin
            case (i_avs_address)
               ADDR_MASK_SET, ADDR_MASK_CLR: begin
                  st_next.rdata = st.chan_mask; // R02
               end
               ADDR_EVT_SET, ADDR_EVT_CLR: begin
                  st_next.rdata = evt_view; // R06
               end
               ADDR_CTRL: begin
                  st_next.rdata[CTRL_LATE_ACK_EN] = st.late_ack_en;
                  st_next.rdata[CTRL_MASTER] = st.master;
               end
               default: begin
                  st_next.rdata = '0;
               end
            endcase
         end
      end else begin
         st_next.wait_req = 1'b1;
      end
   end

   // ----------------------------------------
   // State register
   // ----------------------------------------
   always_ff @(posedge i_clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         st.wait_req <= 1'b1;
         st.rdata <= '0;
         // Real contents undefined; cleared here only for a clean simulation
         st.chan_mask <= RST_CHAN_MASK; // R03
         st.event_bits <= RST_EVENT;
         st.late_ack_en <= 1'b0;
         st.master <= 1'b0;
         st.ovr_run <= 1'b0;
         st.ovr_cnt <= '0;
         st.fatal_src <= '0;
         st.irq_block <= '0;
         st.accept <= 1'b0;
      end else begin
         st <= st_next;
      end
   end

   // ----------------------------------------
   // Outputs
   // ----------------------------------------
   assign o_avs_readdata = st.rdata;
   assign o_avs_waitrequest = st.wait_req;
   assign o_iso_rx_accept = st.accept;
   assign o_rx_channel_mask = st.chan_mask;
   assign o_cycle_master_role = st.master;
   assign o_late_ack_event_enable = st.late_ack_en;
   assign o_ctx_irq_block = st.irq_block;

endmodule
`default_nettype wire

// ===== verilog/iso_evt_pkg.sv
// Notes on behaviour
// [R01] A 1 in bit n of the lower channel mask lets isochronous packets on channel n (0..31) in.
// [R02] The lower channel mask has a set address and a clear address; both read the mask.
// [R03] The lower channel mask has no meaningful value after reset; software programs it first.
// [R04] An event bit goes to 1 on its source's rising edge or on a 1 written at the set address.
// [R05] An event bit stays 1 until a 1 is written to it at the clear address, nothing else clears it.
// [R06] Reading the event register at either address gives events ANDed with the interrupt mask.
// [R07] Event bits 31, 30 and 28 are reserved and always read as zero.
// [R08] Event bit 29 has no hardware source and is set only by software.
// [R09] With late-ack enable on, bit 27 sets on pending receive data, busy responder or tardy ack.
// [R10] Event bit 26 sets when a PHY register data byte arrives.
// [R11] As cycle master, bit 25 sets when over 125 us pass from cycle start send to gap end.
// [R12] A cycle overrun clears the cycle master role bit.
// [R13] Event bit 24 sets when an error stops a subunit, such as a DMA context going dead.
// [R14] While bit 24 is 1, normal interrupts of the contexts that caused it are blocked.
// [R15] Event bit 23 sets when a received cycle start disagrees with local seconds or count.
// [R16] Event bits 7 and 6 are the live OR of masked receive and transmit isochronous events.
// [R17] Writing 0 to a bit at a set or clear address leaves that bit unchanged.
package iso_evt_pkg;

   // ----------------------------------------
   // Register offsets (byte addresses)
   // ----------------------------------------
   localparam logic [7:0] ADDR_MASK_SET = 8'h78;
   localparam logic [7:0] ADDR_MASK_CLR = 8'h7c;
   localparam logic [7:0] ADDR_EVT_SET = 8'h80;
   localparam logic [7:0] ADDR_EVT_CLR = 8'h84;
   localparam logic [7:0] ADDR_CTRL = 8'h88;

   // ----------------------------------------
   // Field positions
   // ----------------------------------------
   localparam int BIT_SOFTWARE = 29;
   localparam int BIT_LATE_ACK = 27;
   localparam int BIT_PHY_REG = 26;
   localparam int BIT_OVERRUN = 25;
   localparam int BIT_FATAL = 24;
   localparam int BIT_MISMATCH = 23;
   localparam int BIT_ISO_RX = 7;
   localparam int BIT_ISO_TX = 6;
   localparam int CTRL_LATE_ACK_EN = 0;
   localparam int CTRL_MASTER = 1;
   // Only these event bits are held in flops; the rest read zero, except live bits 7 and 6
   localparam logic [31:0] EVT_LATCH_MASK = 32'h2f80_0000;

   // ----------------------------------------
   // Reset values
   // ----------------------------------------
   localparam logic [31:0] RST_CHAN_MASK = 32'h0000_0000;
   localparam logic [31:0] RST_EVENT = 32'h0000_0000;

   // ----------------------------------------
   // Timing
   // ----------------------------------------
   localparam int CLK_PERIOD_NS = 100;
   localparam int CYCLE_LIMIT_NS = 125000;
   localparam int OVR_CYC = CYCLE_LIMIT_NS / CLK_PERIOD_NS;
   localparam int OVR_W = 11;
   localparam logic [OVR_W-1:0] OVR_LIMIT = OVR_W'(OVR_CYC);

   // ----------------------------------------
   // Sizes
   // ----------------------------------------
   localparam int CTX_NUM = 4;
   localparam int EDGE_NUM = 4 + CTX_NUM;

   // ----------------------------------------
   // Block state
   // ----------------------------------------
   typedef struct packed {
      logic wait_req;
      logic [31:0] rdata;
      logic [31:0] chan_mask;
      logic [31:0] event_bits;
      logic late_ack_en;
      logic master;
      logic ovr_run;
      logic [OVR_W-1:0] ovr_cnt;
      logic [CTX_NUM-1:0] fatal_src;
      logic [CTX_NUM-1:0] irq_block;
      logic accept;
   } evt_state_t;

endpackage

// ===== verilog/rise_detect.sv
`timescale 1ns/1ns
`default_nettype none
module rise_detect
   import iso_evt_pkg::*;
#(
   parameter int W = EDGE_NUM
) (
   input wire logic i_clk_sys, // Block clock
   input wire logic i_rst_n, // Synchronised reset, active low
   input wire logic [W-1:0] i_level, // Source levels
   output logic [W-1:0] o_rise // One-cycle pulse per rising edge
);

   logic [W-1:0] prev_reg;

   // Held low through reset so a source already high fires once after release
   always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
      if (!i_rst_n) begin
         prev_reg <= '0;
      end else begin
         prev_reg <= i_level;
      end
   end

   assign o_rise = i_level & ~prev_reg;

endmodule
`default_nettype wire

// ===== testbench/iso_evt_core_properties.sv
`timescale 1ns/1ns
`default_nettype none
module iso_evt_core_properties
   import iso_evt_pkg::*;
(
   input wire logic i_clk_sys, // Clock
   input wire logic i_nrst, // Reset
   input wire logic [7:0] i_avs_address, // Address
   input wire logic i_avs_read, // Read
   input wire logic i_avs_write, // Write
   input wire logic [31:0] o_avs_readdata, // Data
   input wire logic o_avs_waitrequest, // Stall
   input wire logic [31:0] i_intr_mask, // Mask
   input wire logic i_iso_rx_valid, // Header
   input wire logic [5:0] i_iso_rx_channel, // Channel
   input wire logic o_iso_rx_accept, // Taken
   input wire logic [31:0] o_rx_channel_mask, // Enables
   input wire logic i_cycle_start_tx, // Start
   input wire logic i_subaction_gap_end, // Gap
   input wire logic o_cycle_master_role // Master
);
   localparam int OVR_EDGE = OVR_CYC + 1;
   logic run_reg;
   logic [11:0] cnt_reg;
   wire logic acc_want = i_iso_rx_valid && !i_iso_rx_channel[5]
      && o_rx_channel_mask[i_iso_rx_channel[4:0]];
   wire logic mask_wr = i_avs_write && !o_avs_waitrequest
      && (i_avs_address == ADDR_MASK_SET || i_avs_address == ADDR_MASK_CLR);
   wire logic evt_rd = i_avs_read && !o_avs_waitrequest
      && (i_avs_address == ADDR_EVT_SET || i_avs_address == ADDR_EVT_CLR);
   default clocking cb @(posedge i_clk_sys);
   endclocking
   default disable iff (!i_nrst);
   // ----------------------------------------
   // Overrun watch: counts edges since a cycle start send
   // ----------------------------------------
   always_ff @(posedge i_clk_sys or negedge i_nrst) begin
      if (!i_nrst) begin
         run_reg <= 1'b0;
         cnt_reg <= 12'h000;
      end else if (i_cycle_start_tx && o_cycle_master_role && !run_reg) begin
         run_reg <= 1'b1;
         cnt_reg <= 12'h000;
      end else if (run_reg) begin
         run_reg <= !i_subaction_gap_end && cnt_reg != 12'(OVR_EDGE);
         cnt_reg <= cnt_reg + 12'h001;
      end
   end
   property p_wait_ans;
      (i_avs_read || i_avs_write) && o_avs_waitrequest |=> !o_avs_waitrequest;
   endproperty
   a_wait_ans: assert property (p_wait_ans) else $error("bus request unanswered");
   property p_wait_one;
      $fell(o_avs_waitrequest) |-> $past(i_avs_read || i_avs_write) ##1 o_avs_waitrequest;
   endproperty
   a_wait_one: assert property (p_wait_one) else $error("bus answer malformed");
   property p_acc_on;
      acc_want |=> o_iso_rx_accept;
   endproperty
   a_acc_on: assert property (p_acc_on) else $error("enabled channel not taken");
   property p_acc_off;
      o_iso_rx_accept |-> $past(acc_want);
   endproperty
   a_acc_off: assert property (p_acc_off) else $error("disabled channel taken");
   property p_mask_chg;
      $changed(o_rx_channel_mask) |-> $past(mask_wr);
   endproperty
   a_mask_chg: assert property (p_mask_chg) else $error("channel mask changed alone");
   property p_rsvd;
      evt_rd |-> o_avs_readdata[31:30] == 2'h0 && !o_avs_readdata[28];
   endproperty
   a_rsvd: assert property (p_rsvd) else $error("reserved event bit read as one");
   property p_evt_mask;
      evt_rd |-> (o_avs_readdata & ~$past(i_intr_mask)) == 32'h0;
   endproperty
   a_evt_mask: assert property (p_evt_mask) else $error("event read not masked");
   property p_ovr_clr;
      run_reg && cnt_reg == 12'(OVR_EDGE) |-> !o_cycle_master_role;
   endproperty
   a_ovr_clr: assert property (p_ovr_clr) else $error("master kept after overrun");
endmodule
bind iso_evt_core iso_evt_core_properties chk (
   .i_clk_sys(i_clk_sys), .i_nrst(i_nrst), .i_avs_address(i_avs_address),
   .i_avs_read(i_avs_read), .i_avs_write(i_avs_write), .o_avs_readdata(o_avs_readdata),
   .o_avs_waitrequest(o_avs_waitrequest), .i_intr_mask(i_intr_mask),
   .i_iso_rx_valid(i_iso_rx_valid), .i_iso_rx_channel(i_iso_rx_channel),
   .o_iso_rx_accept(o_iso_rx_accept), .o_rx_channel_mask(o_rx_channel_mask),
   .i_cycle_start_tx(i_cycle_start_tx), .i_subaction_gap_end(i_subaction_gap_end),
   .o_cycle_master_role(o_cycle_master_role)
);
`default_nettype wire

// ===== testbench/iso_evt_core_test.sv
`timescale 1ns/1ns
`default_nettype none
module iso_evt_core_test
   import iso_evt_pkg::*;
;
   localparam logic [31:0] MV = 32'h8000_ff01;
   localparam logic [47:0] CHL = {6'h3f, 6'h20, 6'h1f, 6'h10, 6'h0f, 6'h08, 6'h01, 6'h00};
   logic clk, nrst, rd, wr, vld, cs_tx, gap, cs_rx, wt, acc, mst, lae;
   logic [7:0] adr, src;
   logic [31:0] wd, rdat, imask, rdo, cmask, lct;
   logic [3:0] be, rxe, rxm, txe, txm, blk;
   logic [5:0] ch;
   logic [6:0] sec;
   logic [12:0] cnt;
   int fail_count, checks_done, k, b;
   iso_evt_core dut (
      .i_clk_sys(clk), .i_nrst(nrst), .i_avs_address(adr), .i_avs_read(rd),
      .i_avs_write(wr), .i_avs_writedata(wd), .i_avs_byteenable(be), .o_avs_readdata(rdo),
      .o_avs_waitrequest(wt), .i_intr_mask(imask), .i_iso_rx_valid(vld),
      .i_iso_rx_channel(ch), .o_iso_rx_accept(acc), .o_rx_channel_mask(cmask),
      .i_rx_fifo_pending(src[0]), .i_phys_resp_busy(src[1]), .i_ack_tardy_sent(src[2]),
      .i_phy_reg_byte_received(src[3]), .i_context_dead(src[7:4]), .i_cycle_start_tx(cs_tx),
      .i_subaction_gap_end(gap), .i_rx_cycle_start(cs_rx), .i_rx_cycle_seconds_count(sec),
      .i_rx_cycle_count_value(cnt), .i_local_cycle_time(lct),
      .i_iso_rx_ctx_event(rxe), .i_iso_rx_ctx_mask(rxm), .i_iso_tx_ctx_event(txe),
      .i_iso_tx_ctx_mask(txm), .o_cycle_master_role(mst), .o_late_ack_event_enable(lae),
      .o_ctx_irq_block(blk)
   );
   // ----------------------------------------
   // Bus and report tasks
   // ----------------------------------------
   task automatic check(input string n, input logic [31:0] got, input logic [31:0] exp);
      checks_done++;
      if (got !== exp) begin
         fail_count++;
         $display("Error %s expected %h seen %h", n, exp, got);
      end
   endtask
   task automatic end_sim();
      $display("checks %0d mismatches %0d", checks_done, fail_count);
      if (fail_count == 0 && checks_done > 0) $display("Run complete: PASS");
      else $display("Run complete: FAIL");
      $finish;
   endtask
   task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
      int i;
      adr <= a;
      wd <= d;
      wr <= w;
      rd <= !w;
      for (i = 0; i < 20; i++) begin
         @(posedge clk);
         if (wt === 1'b0) break;
      end
      if (i == 20) begin
         fail_count++;
         end_sim();
      end
      rdat = rdo;
      rd <= 1'b0;
      wr <= 1'b0;
      // Idle edge keeps back-to-back calls off the same time step
      @(posedge clk);
   endtask
   task automatic rchk(input string n, input logic [7:0] a, input logic [31:0] e);
      bus(1'b0, a, 32'h0);
      check(n, rdat, e);
   endtask
   initial begin
      clk = 1'b0;
      forever #50 clk = ~clk;
   end
   // ----------------------------------------
   // Main sequence
   // ----------------------------------------
   initial begin
      nrst = 1'b0;
      {rd, wr, vld, cs_tx, gap, cs_rx, adr, src, wd, rxe, rxm, txe, txm, ch, sec, cnt} = '0;
      be = 4'hf;
      imask = 32'hffff_ffff;
      lct = {7'h05, 13'h0064, 12'h000};
      repeat (6) @(posedge clk);
      nrst <= 1'b1;
      repeat (3) @(posedge clk);
      rchk("mask_rst", ADDR_MASK_SET, RST_CHAN_MASK);
      bus(1'b1, ADDR_MASK_SET, 32'h8000_0005);
      bus(1'b1, ADDR_MASK_CLR, 32'h0000_0004);
      bus(1'b1, ADDR_MASK_SET, 32'h0);
      bus(1'b1, ADDR_MASK_CLR, 32'h0);
      rchk("mask_set", ADDR_MASK_SET, 32'h8000_0001);
      be <= 4'h2;
      bus(1'b1, ADDR_MASK_SET, 32'hffff_ffff);
      be <= 4'hf;
      bus(1'b1, 8'h90, 32'hffff_ffff);
      rchk("unmapped", 8'h90, 32'h0);
      rchk("mask_clr", ADDR_MASK_CLR, MV);
      check("mask_out", cmask, MV);
      for (k = 0; k < 8; k++) begin
         ch <= CHL[k*6 +: 6];
         vld <= 1'b1;
         @(posedge clk);
         vld <= 1'b0;
         @(posedge clk);
         check("accept", {31'h0, acc}, {31'h0, CHL[k*6+5] ? 1'b0 : MV[CHL[k*6 +: 5]]});
      end
      $display("mask tests done");
      rchk("evt_rst", ADDR_EVT_SET, RST_EVENT);
      bus(1'b1, ADDR_EVT_SET, 32'hffff_ffff);
      rchk("evt_set", ADDR_EVT_CLR, 32'h2f80_0000);
      imask <= 32'h2400_0000;
      rchk("evt_and", ADDR_EVT_SET, 32'h2400_0000);
      imask <= 32'hffff_ffff;
      bus(1'b1, ADDR_EVT_CLR, 32'h0);
      rchk("evt_keep", ADDR_EVT_SET, 32'h2f80_0000);
      bus(1'b1, ADDR_EVT_CLR, 32'hffff_ffff);
      rchk("evt_clr", ADDR_EVT_SET, 32'h0);
      src[0] <= 1'b1;
      repeat (2) @(posedge clk);
      rchk("lack_off", ADDR_EVT_SET, 32'h0);
      src[0] <= 1'b0;
      bus(1'b1, ADDR_CTRL, 32'h1);
      check("lack_en", {31'h0, lae}, 32'h1);
      for (k = 0; k < 8; k++) begin
         b = (k < 3) ? BIT_LATE_ACK : (k == 3) ? BIT_PHY_REG : BIT_FATAL;
         src[k] <= 1'b1;
         repeat (2) @(posedge clk);
         rchk("src_evt", ADDR_EVT_SET, 32'h1 << b);
         check("irq_blk", {28'h0, blk}, (k > 3) ? 32'h1 << (k - 4) : 32'h0);
         bus(1'b1, ADDR_EVT_CLR, 32'h1 << b);
         rchk("src_level", ADDR_EVT_SET, 32'h0);
         check("irq_rel", {28'h0, blk}, 32'h0);
         src[k] <= 1'b0;
         @(posedge clk);
      end
      for (k = 0; k < 3; k++) begin
         sec <= 7'h05 + 7'(k / 2);
         cnt <= 13'h0064 + 13'(k % 2);
         cs_rx <= 1'b1;
         @(posedge clk);
         cs_rx <= 1'b0;
         repeat (2) @(posedge clk);
         rchk("mismatch", ADDR_EVT_SET, (k > 0) ? 32'h0080_0000 : 32'h0);
         bus(1'b1, ADDR_EVT_CLR, 32'hffff_ffff);
      end
      // Local timer moves too: equal values must not raise the event
      lct <= {7'h06, 13'h0065, 12'h000};
      sec <= 7'h06;
      cnt <= 13'h0065;
      cs_rx <= 1'b1;
      @(posedge clk);
      cs_rx <= 1'b0;
      repeat (2) @(posedge clk);
      rchk("cyc_match", ADDR_EVT_SET, 32'h0);
      {rxe, rxm, txe} <= {4'h2, 4'h2, 4'h1};
      rchk("live_rx", ADDR_EVT_CLR, 32'h0000_0080);
      txm <= 4'h1;
      imask <= 32'h0000_0040;
      rchk("live_tx", ADDR_EVT_SET, 32'h0000_0040);
      {rxe, rxm, txe, txm} <= '0;
      imask <= 32'hffff_ffff;
      $display("event tests done");
      bus(1'b1, ADDR_CTRL, 32'h2);
      check("master", {31'h0, mst}, 32'h1);
      check("lack_dis", {31'h0, lae}, 32'h0);
      be <= 4'he;
      bus(1'b1, ADDR_CTRL, 32'h1);
      be <= 4'hf;
      rchk("ctrl_be", ADDR_CTRL, 32'h2);
      cs_tx <= 1'b1;
      @(posedge clk);
      cs_tx <= 1'b0;
      repeat (100) @(posedge clk);
      gap <= 1'b1;
      @(posedge clk);
      gap <= 1'b0;
      repeat (1300) @(posedge clk);
      check("master_gap", {31'h0, mst}, 32'h1);
      rchk("no_ovr", ADDR_EVT_SET, 32'h0);
      cs_tx <= 1'b1;
      @(posedge clk);
      cs_tx <= 1'b0;
      repeat (OVR_CYC + 5) @(posedge clk);
      check("master_ovr", {31'h0, mst}, 32'h0);
      rchk("ctrl_ovr", ADDR_CTRL, 32'h0);
      rchk("ovr", ADDR_EVT_SET, 32'h0200_0000);
      $display("overrun tests done");
      bus(1'b1, ADDR_MASK_SET, 32'hffff_ffff);
      nrst <= 1'b0;
      repeat (2) @(posedge clk);
      nrst <= 1'b1;
      repeat (3) @(posedge clk);
      rchk("mask_rst2", ADDR_MASK_CLR, RST_CHAN_MASK);
      $display("reset tests done");
      end_sim();
   end
endmodule
`default_nettype wire
